// [core/adc_ctrl.sv]
// Mode decode and conversion-start control for an eight-channel 18-bit converter.
// Assumes pins are synchronous to mclk_in; analog results arrive on sample inputs.
//
// Functional notes
// - Results are 18-bit two's complement, all channels
// - Code step is full-scale span over 2^18
// - Reference select high enables internal band-gap
// - Reference mode follows select pin at once
// - Range high wide span, low narrow
// - Range change immediate; host waits extra 80us
// - Power-down low enters standby or shutdown
// - Shutdown powers all off; standby keeps reference; reference_io_drive_out still follows select in shutdown
// - Interface select decodes parallel, serial, byte
// - Start A converts 1-4, B converts 5-8
// - Start rising edge holds and converts samples
// - Results readable whatever the start levels
// - Busy after both edges; starts ignored meanwhile
// - Reset clears logic and aborts conversion
// - Oversampling averages internal samples into 18 bits
`timescale 1ns/1ns
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic                                  mclk_in,
  input  wire logic                                  sys_rst_in,
  input  wire adc_ctrl_pkg::cfg_pins_t               cfg_in,
  input  wire logic                                  sample_start_group_a_in,
  input  wire logic                                  sample_start_group_b_in,
  input  wire logic [adc_ctrl_pkg::CHAN_N*adc_ctrl_pkg::RESULT_W-1:0] sample_in,
  output adc_ctrl_pkg::mode_status_t                 mode_out,
  output logic                                       reference_io_drive_out,
  output logic                                       hold_group_a_out,
  output logic                                       hold_group_b_out,
  output logic                                       busy_out,
  output logic                                       range_settling_out,
  output logic                                       result_valid_out,
  output logic [adc_ctrl_pkg::CHAN_N*adc_ctrl_pkg::RESULT_W-1:0] result_out
);
  import adc_ctrl_pkg::*;

  localparam int ACC_W = RESULT_W + 6;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_OTHER,
    ST_CONVERT
  } conv_state_t;

  function automatic iface_mode_t decode_iface(input logic sel, input logic byte_sel);
    if (!sel) begin
      decode_iface = IF_PARALLEL;
    end else if (byte_sel) begin
      decode_iface = IF_PARALLEL_BYTE;
    end else begin
      decode_iface = IF_SERIAL;
    end
  endfunction

  function automatic logic [6:0] os_ratio(input logic [2:0] os);
    if (os == OS_INVALID) begin
      os_ratio = 7'h01;
    end else begin
      os_ratio = 7'(7'h01 << os);
    end
  endfunction

  function automatic logic [2:0] oversample_ratio_select_q();
    oversample_ratio_select_q = (cfg_in.oversample_ratio_select == OS_INVALID) ?
                                OS_NONE : cfg_in.oversample_ratio_select;
  endfunction

  function automatic int os_shift(input logic [6:0] ratio);
    os_shift = 0;
    for (int i = 0; i < 7; i++) begin
      if (ratio[i]) begin
        os_shift = i;
      end
    end
  endfunction

  // Mode decode state
  mode_status_t mode_r, mode_nxt;
  logic         range_prev_r, range_prev_nxt;
  logic [14:0]  settle_cnt_r, settle_cnt_nxt;
  logic         settling_r, settling_nxt;

  always_comb begin
    mode_nxt.internal_ref_used = cfg_in.reference_source_select;
    mode_nxt.bandgap_enable    = cfg_in.reference_source_select &&
                                 (cfg_in.power_down_n || !cfg_in.range_wide);
    mode_nxt.ref_buffer_enable = cfg_in.power_down_n || !cfg_in.range_wide;
    mode_nxt.range_wide        = cfg_in.range_wide;
    if (cfg_in.power_down_n) begin
      mode_nxt.power_mode = PWR_NORMAL;
    end else if (cfg_in.range_wide) begin
      mode_nxt.power_mode = PWR_SHUTDOWN;
    end else begin
      mode_nxt.power_mode = PWR_STANDBY;
    end
    mode_nxt.reference_powered = (mode_nxt.power_mode != PWR_SHUTDOWN);
    mode_nxt.core_powered      = (mode_nxt.power_mode == PWR_NORMAL);
    mode_nxt.iface_mode = decode_iface(cfg_in.interface_type_select,
                                       cfg_in.byte_mode_select);
    range_prev_nxt = cfg_in.range_wide;
    settle_cnt_nxt = settle_cnt_r;
    settling_nxt   = settling_r;
    if (range_prev_r != cfg_in.range_wide) begin
      settle_cnt_nxt = 15'(RANGE_SETTLE_CYC - 1);
      settling_nxt   = 1'b1;
    end else if (settle_cnt_r != '0) begin
      settle_cnt_nxt = settle_cnt_r - 15'h0001;
    end else begin
      settling_nxt   = 1'b0;
    end
  end

  // Reference mode captured one edge after reset release, then tracks the pin
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_r       <= '0;
      range_prev_r <= 1'b0;
      settle_cnt_r <= '0;
      settling_r   <= 1'b0;
    end else begin
      mode_r       <= mode_nxt;
      range_prev_r <= range_prev_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      settling_r   <= settling_nxt;
    end
  end

  // Conversion state
  conv_state_t state_r, state_nxt;
  logic        start_a_prev_r, start_b_prev_r;
  logic        hold_a_r, hold_a_nxt, hold_b_r, hold_b_nxt;
  logic [2:0]  div_r, div_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic [6:0]  os_cnt_r, os_cnt_nxt;
  logic [6:0]  os_target_r, os_target_nxt;
  logic        busy_r, busy_nxt;
  logic        valid_r, valid_nxt;
  logic [CHAN_N*RESULT_W-1:0] result_r, result_nxt;
  logic [CHAN_N*ACC_W-1:0]    acc_r, acc_nxt;
  logic        rise_a, rise_b, tick, last_bit;

  assign rise_a   = sample_start_group_a_in && !start_a_prev_r;
  assign rise_b   = sample_start_group_b_in && !start_b_prev_r;
  assign tick     = (div_r == CONV_DIV_LAST);
  assign last_bit = tick && (bit_r == CONV_BITS_LAST);

  always_comb begin
    state_nxt     = state_r;
    hold_a_nxt    = hold_a_r;
    hold_b_nxt    = hold_b_r;
    div_nxt       = '0;
    bit_nxt       = bit_r;
    os_cnt_nxt    = os_cnt_r;
    os_target_nxt = os_target_r;
    busy_nxt      = busy_r;
    valid_nxt     = valid_r;
    result_nxt    = result_r;
    acc_nxt       = acc_r;
    case (state_r)
      ST_IDLE, ST_WAIT_OTHER: begin
        if (rise_a && mode_r.core_powered) begin
          hold_a_nxt = 1'b1;
        end
        if (rise_b && mode_r.core_powered) begin
          hold_b_nxt = 1'b1;
        end
        state_nxt = (hold_a_nxt || hold_b_nxt) ? ST_WAIT_OTHER : ST_IDLE;
        if (hold_a_nxt && hold_b_nxt) begin
          state_nxt     = ST_CONVERT;
          busy_nxt      = 1'b1;
          bit_nxt       = '0;
          os_cnt_nxt    = '0;
          os_target_nxt = os_ratio(oversample_ratio_select_q());
          acc_nxt       = '0;
        end
      end
      ST_CONVERT: begin
        div_nxt = tick ? '0 : 3'(div_r + 3'h1);
        if (tick) begin
          bit_nxt = 5'(bit_r + 5'h01);
        end
        if (last_bit) begin
          bit_nxt = '0;
          for (int c = 0; c < CHAN_N; c++) begin
            acc_nxt[c*ACC_W +: ACC_W] = acc_r[c*ACC_W +: ACC_W] +
              ACC_W'(signed'(sample_in[c*RESULT_W +: RESULT_W]));
          end
          os_cnt_nxt = 7'(os_cnt_r + 7'h01);
          if (os_cnt_nxt == os_target_r) begin
            for (int c = 0; c < CHAN_N; c++) begin
              result_nxt[c*RESULT_W +: RESULT_W] =
                RESULT_W'(signed'(acc_nxt[c*ACC_W +: ACC_W]) >>> os_shift(os_target_r));
            end
            valid_nxt  = 1'b1;
            busy_nxt   = 1'b0;
            hold_a_nxt = 1'b0;
            hold_b_nxt = 1'b0;
            state_nxt  = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r        <= ST_IDLE;
      start_a_prev_r <= 1'b1;
      start_b_prev_r <= 1'b1;
      hold_a_r       <= 1'b0;
      hold_b_r       <= 1'b0;
      div_r          <= '0;
      bit_r          <= '0;
      os_cnt_r       <= '0;
      os_target_r    <= '0;
      busy_r         <= 1'b0;
      valid_r        <= 1'b0;
      result_r       <= {CHAN_N{RESULT_RESET}};
      acc_r          <= '0;
    end else begin
      state_r        <= state_nxt;
      start_a_prev_r <= sample_start_group_a_in;
      start_b_prev_r <= sample_start_group_b_in;
      hold_a_r       <= hold_a_nxt;
      hold_b_r       <= hold_b_nxt;
      div_r          <= div_nxt;
      bit_r          <= bit_nxt;
      os_cnt_r       <= os_cnt_nxt;
      os_target_r    <= os_target_nxt;
      busy_r         <= busy_nxt;
      valid_r        <= valid_nxt;
      result_r       <= result_nxt;
      acc_r          <= acc_nxt;
    end
  end

  assign mode_out               = mode_r;
  assign reference_io_drive_out = mode_r.internal_ref_used;
  assign hold_group_a_out       = hold_a_r;
  assign hold_group_b_out       = hold_b_r;
  assign busy_out               = busy_r;
  assign range_settling_out     = settling_r;
  assign result_valid_out       = valid_r;
  assign result_out             = result_r;

  // Busy rises at the edge that completes the second hold
  sequence s_both_held;
    !busy_out ##1 (hold_group_a_out && hold_group_b_out);
  endsequence

  a_busy_rise_after: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    s_both_held |-> busy_out)
    else $error("busy did not rise after both starts");

  a_starts_ignored_busy: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (busy_out && state_nxt == ST_CONVERT) |=>
      $stable(os_target_r) && hold_group_a_out && hold_group_b_out)
    else $error("start activity changed a running conversion");

  a_hold_needs_edge: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ($rose(hold_group_a_out)) |-> $past(sample_start_group_a_in))
    else $error("hold without start edge");

  a_group_b_maps: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ($rose(hold_group_b_out)) |-> $past(sample_start_group_b_in))
    else $error("group b hold without its start");

  a_power_decode: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (!cfg_in.power_down_n && cfg_in.range_wide) |=> mode_out.power_mode == PWR_SHUTDOWN)
    else $error("shutdown not decoded");

  a_standby_keeps_ref: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (mode_out.power_mode == PWR_STANDBY) |-> mode_out.reference_powered &&
      mode_out.ref_buffer_enable &&
      (mode_out.bandgap_enable == mode_out.internal_ref_used))
    else $error("standby lost reference");

  a_ref_follows_pin: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $changed(cfg_in.reference_source_select) |=>
      mode_out.internal_ref_used == $past(cfg_in.reference_source_select))
    else $error("reference mode lagged pin");

  a_iface_serial: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (cfg_in.interface_type_select && !cfg_in.byte_mode_select) |=>
      mode_out.iface_mode == IF_SERIAL)
    else $error("serial mode not decoded");

  a_range_settle: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $changed(cfg_in.range_wide) |=> range_settling_out ##1 range_settling_out)
    else $error("range settle not flagged");

  a_valid_on_finish: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $fell(busy_out) |-> result_valid_out && !hold_group_a_out)
    else $error("results not latched at busy fall");

endmodule // adc_ctrl

// [core/adc_ctrl_pkg.sv]
// Package for the converter mode and conversion-start control block.
// Assumes a single 250 MHz clock and pin-level inputs synchronous to it.
package adc_ctrl_pkg;

  localparam int          RESULT_W        = 18;
  localparam int          CHAN_N          = 8;
  localparam int          GROUP_CHANS     = 4;
  localparam int          CLK_PERIOD_NS   = 4;
  // Code step in nanovolts, full-scale span over two to the eighteenth
  localparam int          LSB_WIDE_NV     = 76295;
  localparam int          LSB_NARROW_NV   = 38148;
  // Settling after a range change, in microseconds, and its cycle count
  localparam int          RANGE_SETTLE_US = 80;
  localparam int          RANGE_SETTLE_CYC = RANGE_SETTLE_US * 1000 / CLK_PERIOD_NS;
  // Internal conversion clock divider and conversion length in its ticks
  localparam int          CONV_DIV        = 4;
  localparam logic [2:0]  CONV_DIV_LAST   = 3'h3;
  localparam logic [4:0]  CONV_BITS_LAST  = 5'h11;
  localparam logic [6:0]  OS_RATIO_MAX    = 7'h40;
  localparam logic [2:0]  OS_INVALID      = 3'h7;
  localparam logic [2:0]  OS_NONE         = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 18'h00000;

  typedef enum logic [1:0] {
    IF_PARALLEL,
    IF_SERIAL,
    IF_PARALLEL_BYTE
  } iface_mode_t;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_STANDBY,
    PWR_SHUTDOWN
  } power_mode_t;

  typedef struct packed {
    logic reference_source_select;
    logic range_wide;
    logic power_down_n;
    logic interface_type_select;
    logic byte_mode_select;
    logic [2:0] oversample_ratio_select;
  } cfg_pins_t;

  typedef struct packed {
    logic        bandgap_enable;
    logic        internal_ref_used;
    logic        ref_buffer_enable;
    logic        range_wide;
    power_mode_t power_mode;
    logic        reference_powered;
    logic        core_powered;
    iface_mode_t iface_mode;
  } mode_status_t;

endpackage

// [dv/adc_host_model.sv]
// Host model that drives the configuration and conversion-start pins.
// Assumes its tasks are called 1 ns after a rising edge of mclk_in.
`timescale 1ns/1ns
module adc_host_model
  import adc_ctrl_pkg::*;
#(
  parameter int RECOVERY_CYC = 8
)(
  input  wire logic                mclk_in,
  output adc_ctrl_pkg::cfg_pins_t  cfg_out,
  output logic                     start_a_out,
  output logic                     start_b_out
);
  import adc_ctrl_pkg::*;

  initial begin
    cfg_out     = '0;
    start_a_out = 1'b0;
    start_b_out = 1'b0;
  end

  // Waits out the recovery time when leaving power-down
  task automatic set_cfg(input cfg_pins_t c);
    logic waking;
    waking  = c.power_down_n & ~cfg_out.power_down_n;
    cfg_out = c;
    if (waking) begin
      repeat (RECOVERY_CYC) @(posedge mclk_in);
      #1;
    end
  endtask

  // Group B follows group A after gap cycles; tied together when oversampling
  task automatic raise_starts(input int gap);
    if (cfg_out.oversample_ratio_select != OS_NONE &&
        cfg_out.oversample_ratio_select != OS_INVALID) begin
      gap = 0;
    end
    start_a_out = 1'b1;
    if (gap > 0) begin
      repeat (gap) @(posedge mclk_in);
      #1;
    end
    start_b_out = 1'b1;
  endtask

  task automatic drop_starts();
    start_a_out = 1'b0;
    start_b_out = 1'b0;
  endtask
endmodule // adc_host_model

// [dv/adc_ctrl_tb_top.sv]
// Self-checking testbench for the converter mode and conversion-start control.
// Assumes the host model drives the pins; the bench drives samples and reset.
`timescale 1ns/1ns
module adc_ctrl_tb_top;
  import adc_ctrl_pkg::*;

  logic                       mclk_in;
  logic                       sys_rst_in;
  cfg_pins_t                  cfg;
  logic                       start_a;
  logic                       start_b;
  logic [CHAN_N*RESULT_W-1:0] sample;
  logic [CHAN_N*RESULT_W-1:0] result;
  mode_status_t               mode;
  logic                       ref_drive;
  logic                       hold_a;
  logic                       hold_b;
  logic                       busy;
  logic                       settling;
  logic                       valid;
  int                         err_count;
  int                         n_checks;
  int                         n;

  adc_host_model host (.mclk_in(mclk_in), .cfg_out(cfg), .start_a_out(start_a),
                       .start_b_out(start_b));

  adc_ctrl dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cfg_in(cfg),
    .sample_start_group_a_in(start_a), .sample_start_group_b_in(start_b),
    .sample_in(sample), .mode_out(mode), .reference_io_drive_out(ref_drive),
    .hold_group_a_out(hold_a), .hold_group_b_out(hold_b), .busy_out(busy),
    .range_settling_out(settling), .result_valid_out(valid), .result_out(result));

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [143:0] exp, input logic [143:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  // Counts cycles until busy falls, bounded
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (busy === 1'b1) begin
      tick(1);
      cnt++;
      if (cnt > 6000) begin
        err_count++;
        finish_test();
      end
    end
  endtask

  task automatic mode_case(input logic [4:0] v);
    cfg_pins_t c;
    c = cfg;
    {c.reference_source_select, c.range_wide, c.power_down_n} = v[4:2];
    {c.interface_type_select, c.byte_mode_select} = v[1:0];
    host.set_cfg(c);
    tick(2);
    chk("bandgap", v[4] & (v[2] | ~v[3]), mode.bandgap_enable);
    if (v[2]) chk("int_ref", v[4], mode.internal_ref_used);
    if (v[2]) chk("ref_buf", 1'b1, mode.ref_buffer_enable);
    if (v[2]) chk("ref_drive", v[4], ref_drive);
    chk("range", v[3], mode.range_wide);
    chk("power", v[2] ? PWR_NORMAL : (v[3] ? PWR_SHUTDOWN : PWR_STANDBY),
        mode.power_mode);
    if (!v[2]) chk("ref_pwr", !v[3], mode.reference_powered);
    chk("core_pwr", v[2], mode.core_powered);
    chk("iface", !v[1] ? IF_PARALLEL : (v[0] ? IF_PARALLEL_BYTE : IF_SERIAL),
        mode.iface_mode);
  endtask

  task automatic convert(input logic [2:0] code, input logic glitch);
    cfg_pins_t c;
    int ratio;
    c = cfg;
    c.oversample_ratio_select = code;
    host.set_cfg(c);
    ratio = (code == 3'h7) ? 1 : (1 << code);
    host.raise_starts(0);
    chk("busy_early", 1'b0, busy);
    tick(1);
    chk("hold_a", 1'b1, hold_a);
    chk("hold_b", 1'b1, hold_b);
    chk("busy", 1'b1, busy);
    if (glitch) begin
      host.drop_starts();
      tick(1);
      host.raise_starts(0);
      tick(1);
    end
    wait_idle(n);
    chk("conv_len", 72 * ratio, n + (glitch ? 2 : 0));
    chk("hold_end", 1'b0, hold_a | hold_b);
    chk("valid", 1'b1, valid);
    chk("result", sample, result);
    host.drop_starts();
    tick(1);
  endtask

  initial begin
    cfg_pins_t c;
    err_count  = 0;
    n_checks   = 0;
    sys_rst_in = 1'b1;
    for (int i = 0; i < CHAN_N; i++) begin
      sample[i*RESULT_W+:RESULT_W] = i[0] ? 18'(18'h3fff0 - i) : 18'(18'h01234 + i);
    end
    tick(20);
    chk("rst_busy", 1'b0, busy | hold_a | hold_b | valid);
    chk("rst_result", '0, result);
    sys_rst_in = 1'b0;
    tick(2);
    for (int i = 0; i < 32; i++) mode_case(5'(i));
    c = cfg;
    c.range_wide = 1'b0;
    host.set_cfg(c);
    tick(2);
    chk("settling", 1'b1, settling);
    n = 0;
    while (settling === 1'b1 && n < 25000) begin
      tick(1);
      n++;
    end
    if (n >= 25000) begin
      err_count++;
      finish_test();
    end
    chk("settle_len", 1'b1, n >= RANGE_SETTLE_CYC - 4 && n <= RANGE_SETTLE_CYC + 4);
    for (int k = 0; k < 8; k++) convert(3'(k), k == 0);
    // Group A alone holds only its own half
    fork
      host.raise_starts(10);
      begin
        tick(4);
        chk("split_a", 2'b10, {hold_a, hold_b});
        chk("split_busy", 1'b0, busy);
      end
    join
    tick(2);
    chk("split_b", 2'b11, {hold_a, hold_b});
    tick(1);
    wait_idle(n);
    chk("split_result", sample, result);
    host.drop_starts();
    tick(1);
    c = cfg;
    c.power_down_n = 1'b0;
    host.set_cfg(c);
    tick(1);
    host.raise_starts(0);
    tick(4);
    chk("pd_refused", 1'b0, hold_a | hold_b | busy);
    host.drop_starts();
    c.power_down_n = 1'b1;
    host.set_cfg(c);
    host.raise_starts(0);
    tick(20);
    chk("abort_busy", 1'b1, busy);
    sys_rst_in = 1'b1;
    #1;
    chk("abort", 1'b0, busy | valid | hold_a);
    chk("abort_result", '0, result);
    host.drop_starts();
    tick(3);
    sys_rst_in = 1'b0;
    tick(3);
    chk("after_rst", 1'b0, busy | valid);
    finish_test();
  end
endmodule // adc_ctrl_tb_top
